// ---- verilog/irq_ctrl_map.vh ----
// register map and field constants for the eight-source interrupt controller
// Behaviour
// - extra control register at 0C0H, bit-addressable
// - bit set/clear; bit 0C2H is ext2 enable
// - priority bit selects high or low level
// - cleared enable blocks the source
// - type bit: set edge, clear low level
// - edge sets flag, vectoring clears it
// - fixed vectors, polling order within level
// - ext0 enable IE.0, type TIMER_CONTROL.0
// - ext2 enable bit2, type bit0; ext3 bit6
// - aux port pins feed ext2/ext3 in I/O mode
// - writing idle bit enters idle
// - idle gates core clock, interrupts keep clock
// - idle exits on enabled interrupt or reset
// - power-down bit stops all clocks
// - power-down exits on reset or level ext0/1
// - registers reset to 00H, power bits 4 and 5 set
`ifndef IRQ_CTRL_MAP_VH
`define IRQ_CTRL_MAP_VH
`define ADDR_POWER_CONTROL   8'h87
`define ADDR_TIMER_CONTROL   8'h88
`define ADDR_INT_ENABLE      8'ha8
`define ADDR_INT_PRIORITY    8'hb8
`define ADDR_EXTRA_CONTROL   8'hc0
`define BITADDR_EXTRA_BASE   5'h18
`define BITADDR_TIMER_CONTROL_BASE    5'h11
`define RESET_ZERO           8'h00
`define RESET_POWER_CONTROL  8'h30
`define POWER_CONTROL_IDLE_BIT        0
`define POWER_CONTROL_PDOWN_BIT       1
`define TIMER_CONTROL_IT0_BIT         0
`define TIMER_CONTROL_IE0_BIT         1
`define TIMER_CONTROL_IT1_BIT         2
`define TIMER_CONTROL_IE1_BIT         3
`define TIMER_CONTROL_TF0_BIT         5
`define TIMER_CONTROL_TF1_BIT         7
`define XC_IT2_BIT           0
`define XC_IE2_BIT           1
`define XC_EX2_BIT           2
`define XC_PX2_BIT           3
`define XC_IT3_BIT           4
`define XC_IE3_BIT           5
`define XC_EX3_BIT           6
`define XC_PX3_BIT           7
`define IE_GLOBAL_BIT        7
`define VEC_BASE             8'h03
`define VEC_STEP_SHIFT       3
`define PORT_MODE_GPIO       2'h0
`define BITADDR_IE_BASE      5'h15
`define BITADDR_IP_BASE      5'h17
`define IE_EX0_BIT           0
`define IE_EX1_BIT           2
`define SRC_EXT0             3'h0
`define SRC_TMR0             3'h1
`define SRC_EXT1             3'h2
`define SRC_TMR1             3'h3
`define SRC_SERIAL           3'h4
`define SRC_TMR2             3'h5
`define SRC_EXT2             3'h6
`define SRC_EXT3             3'h7
`endif

// ---- verilog/eight_source_irq_and_wakeup.v ----
// eight-source two-level interrupt controller with idle and power-down
`timescale 1ns/10ps
`default_nettype none
`include "irq_ctrl_map.vh"
module eight_source_irq_and_wakeup #(
    parameter NSRC = 8
) (
    input  wire       clk_i,
    input  wire       rst_i,
    input  wire [7:0] sfr_addr_i,
    input  wire [7:0] sfr_wdata_i,
    input  wire       sfr_wr_i,
    input  wire       sfr_rd_i,
    input  wire [7:0] bit_addr_i,
    input  wire       bit_wr_i,
    input  wire       bit_val_i,
    input  wire       ext_request_zero_n_i,
    input  wire       ext_request_one_n_i,
    input  wire       aux_port_pin_two_i,
    input  wire       aux_port_pin_three_i,
    input  wire [1:0] aux_pin_two_mode_i,
    input  wire [1:0] aux_pin_three_mode_i,
    input  wire       timer0_ovf_i,
    input  wire       timer1_ovf_i,
    input  wire       serial_irq_i,
    input  wire       timer2_irq_i,
    input  wire       irq_ack_i,
    input  wire       reti_i,
    output reg  [7:0] sfr_rdata_o,
    output reg        irq_req_o,
    output reg  [7:0] irq_vector_o,
    output reg        core_clk_en_o,
    output reg        osc_run_o
);

    reg [7:0] power_control_q;
    reg [7:0] timer_control_q;
    reg [7:0] ie_q;
    reg [7:0] ip_q;
    reg [7:0] extra_irq_control_q;
    reg       e0_prev_q;
    reg       e1_prev_q;
    reg       e2_prev_q;
    reg       e3_prev_q;
    reg       in_hi_q;
    reg       in_lo_q;
    reg [2:0] sel_q;

    // port-4 pins feed ext2/ext3 only in general I/O mode
    wire e2_n = (aux_pin_three_mode_i == `PORT_MODE_GPIO) ?
                aux_port_pin_three_i : 1'b1;
    wire e3_n = (aux_pin_two_mode_i == `PORT_MODE_GPIO) ?
                aux_port_pin_two_i : 1'b1;

    wire fall0 = e0_prev_q & ~ext_request_zero_n_i;
    wire fall1 = e1_prev_q & ~ext_request_one_n_i;
    wire fall2 = e2_prev_q & ~e2_n;
    wire fall3 = e3_prev_q & ~e3_n;

    // level-mode flags track the pin; edge-mode flags are sticky
    wire f0 = timer_control_q[`TIMER_CONTROL_IT0_BIT] ? timer_control_q[`TIMER_CONTROL_IE0_BIT]
                                    : ~ext_request_zero_n_i;
    wire f1 = timer_control_q[`TIMER_CONTROL_IT1_BIT] ? timer_control_q[`TIMER_CONTROL_IE1_BIT]
                                    : ~ext_request_one_n_i;
    wire f2 = extra_irq_control_q[`XC_IT2_BIT] ? extra_irq_control_q[`XC_IE2_BIT] : ~e2_n;
    wire f3 = extra_irq_control_q[`XC_IT3_BIT] ? extra_irq_control_q[`XC_IE3_BIT] : ~e3_n;

    wire [7:0] flag = {f3, f2, timer2_irq_i, serial_irq_i,
                       timer_control_q[`TIMER_CONTROL_TF1_BIT], f1,
                       timer_control_q[`TIMER_CONTROL_TF0_BIT], f0};
    wire [7:0] en = {extra_irq_control_q[`XC_EX3_BIT], extra_irq_control_q[`XC_EX2_BIT],
                     ie_q[5:0]};
    wire [7:0] pri = {extra_irq_control_q[`XC_PX3_BIT], extra_irq_control_q[`XC_PX2_BIT],
                      ip_q[5:0]};
    wire [7:0] act = flag & en & {NSRC{ie_q[`IE_GLOBAL_BIT]}};
    wire [7:0] act_hi = act & pri;
    wire [7:0] act_lo = act & ~pri;

    // fixed polling order inside each level, first source highest
    reg [2:0] hi_idx;
    reg [2:0] lo_idx;
    always @* begin
        hi_idx = `SRC_EXT0;
        if (act_hi[`SRC_EXT0]) begin
            hi_idx = `SRC_EXT0;
        end else if (act_hi[`SRC_TMR0]) begin
            hi_idx = `SRC_TMR0;
        end else if (act_hi[`SRC_EXT1]) begin
            hi_idx = `SRC_EXT1;
        end else if (act_hi[`SRC_TMR1]) begin
            hi_idx = `SRC_TMR1;
        end else if (act_hi[`SRC_SERIAL]) begin
            hi_idx = `SRC_SERIAL;
        end else if (act_hi[`SRC_TMR2]) begin
            hi_idx = `SRC_TMR2;
        end else if (act_hi[`SRC_EXT2]) begin
            hi_idx = `SRC_EXT2;
        end else if (act_hi[`SRC_EXT3]) begin
            hi_idx = `SRC_EXT3;
        end
    end
    always @* begin
        lo_idx = `SRC_EXT0;
        if (act_lo[`SRC_EXT0]) begin
            lo_idx = `SRC_EXT0;
        end else if (act_lo[`SRC_TMR0]) begin
            lo_idx = `SRC_TMR0;
        end else if (act_lo[`SRC_EXT1]) begin
            lo_idx = `SRC_EXT1;
        end else if (act_lo[`SRC_TMR1]) begin
            lo_idx = `SRC_TMR1;
        end else if (act_lo[`SRC_SERIAL]) begin
            lo_idx = `SRC_SERIAL;
        end else if (act_lo[`SRC_TMR2]) begin
            lo_idx = `SRC_TMR2;
        end else if (act_lo[`SRC_EXT2]) begin
            lo_idx = `SRC_EXT2;
        end else if (act_lo[`SRC_EXT3]) begin
            lo_idx = `SRC_EXT3;
        end
    end

    // high may preempt low; nothing preempts high
    wire take_hi = (|act_hi) & ~in_hi_q;
    wire take_lo = (|act_lo) & ~in_hi_q & ~in_lo_q;
    wire want = take_hi | take_lo;
    wire [2:0] win = take_hi ? hi_idx : lo_idx;

    // bit- and byte-addressed write decodes for the extra control, timer, enable and priority registers
    wire bit_x = bit_wr_i &&
                 (bit_addr_i[7:3] == `BITADDR_EXTRA_BASE);
    wire bit_t = bit_wr_i &&
                 (bit_addr_i[7:3] == `BITADDR_TIMER_CONTROL_BASE);
    wire byte_x = sfr_wr_i && (sfr_addr_i == `ADDR_EXTRA_CONTROL);
    wire byte_t = sfr_wr_i && (sfr_addr_i == `ADDR_TIMER_CONTROL);
    wire bit_e = bit_wr_i &&
                 (bit_addr_i[7:3] == `BITADDR_IE_BASE);
    wire bit_p = bit_wr_i &&
                 (bit_addr_i[7:3] == `BITADDR_IP_BASE);
    wire byte_e = sfr_wr_i && (sfr_addr_i == `ADDR_INT_ENABLE);
    wire byte_p = sfr_wr_i && (sfr_addr_i == `ADDR_INT_PRIORITY);
    // an ack only counts while the request stands
    wire svc = irq_ack_i && irq_req_o;

    // a byte write wins over a bit write in the same cycle
    reg [7:0] ie_d;
    reg [7:0] ip_d;
    always @* begin
        ie_d = ie_q;
        ip_d = ip_q;
        if (byte_e) begin
            ie_d = sfr_wdata_i;
        end else if (bit_e) begin
            ie_d[bit_addr_i[2:0]] = bit_val_i;
        end
        if (byte_p) begin
            ip_d = sfr_wdata_i;
        end else if (bit_p) begin
            ip_d[bit_addr_i[2:0]] = bit_val_i;
        end
    end

    reg [7:0] extra_irq_control_d;
    reg [7:0] timer_control_d;
    always @* begin
        extra_irq_control_d = extra_irq_control_q;
        timer_control_d = timer_control_q;
        if (byte_x) begin
            extra_irq_control_d = sfr_wdata_i;
        end else if (bit_x) begin
            extra_irq_control_d[bit_addr_i[2:0]] = bit_val_i;
        end
        if (byte_t) begin
            timer_control_d = sfr_wdata_i;
        end else if (bit_t) begin
            timer_control_d[bit_addr_i[2:0]] = bit_val_i;
        end
        // vectoring clears edge flags; a new edge still wins
        if (svc) begin
            if (sel_q == `SRC_EXT0 && timer_control_q[`TIMER_CONTROL_IT0_BIT]) begin
                timer_control_d[`TIMER_CONTROL_IE0_BIT] = 1'b0;
            end
            if (sel_q == `SRC_TMR0) begin
                timer_control_d[`TIMER_CONTROL_TF0_BIT] = 1'b0;
            end
            if (sel_q == `SRC_EXT1 && timer_control_q[`TIMER_CONTROL_IT1_BIT]) begin
                timer_control_d[`TIMER_CONTROL_IE1_BIT] = 1'b0;
            end
            if (sel_q == `SRC_TMR1) begin
                timer_control_d[`TIMER_CONTROL_TF1_BIT] = 1'b0;
            end
            if (sel_q == `SRC_EXT2 && extra_irq_control_q[`XC_IT2_BIT]) begin
                extra_irq_control_d[`XC_IE2_BIT] = 1'b0;
            end
            if (sel_q == `SRC_EXT3 && extra_irq_control_q[`XC_IT3_BIT]) begin
                extra_irq_control_d[`XC_IE3_BIT] = 1'b0;
            end
        end
        if (fall0) begin
            timer_control_d[`TIMER_CONTROL_IE0_BIT] = 1'b1;
        end
        if (fall1) begin
            timer_control_d[`TIMER_CONTROL_IE1_BIT] = 1'b1;
        end
        if (timer0_ovf_i) begin
            timer_control_d[`TIMER_CONTROL_TF0_BIT] = 1'b1;
        end
        if (timer1_ovf_i) begin
            timer_control_d[`TIMER_CONTROL_TF1_BIT] = 1'b1;
        end
        if (fall2 && extra_irq_control_q[`XC_IT2_BIT]) begin
            extra_irq_control_d[`XC_IE2_BIT] = 1'b1;
        end
        if (fall3 && extra_irq_control_q[`XC_IT3_BIT]) begin
            extra_irq_control_d[`XC_IE3_BIT] = 1'b1;
        end
    end

    // level ext0/1 wake from power-down; needs no running clock in silicon
    wire pd_wake = (ie_q[`IE_GLOBAL_BIT] &&
                    ((ie_q[`IE_EX0_BIT] && !timer_control_q[`TIMER_CONTROL_IT0_BIT] &&
                      !ext_request_zero_n_i) ||
                     (ie_q[`IE_EX1_BIT] && !timer_control_q[`TIMER_CONTROL_IT1_BIT] &&
                      !ext_request_one_n_i)));

    // pin history for falling edges; idles high as the pins do
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            e0_prev_q <= 1'b1;
            e1_prev_q <= 1'b1;
            e2_prev_q <= 1'b1;
            e3_prev_q <= 1'b1;
        end else begin
            e0_prev_q <= ext_request_zero_n_i;
            e1_prev_q <= ext_request_one_n_i;
            e2_prev_q <= e2_n;
            e3_prev_q <= e3_n;
        end
    end

    // control registers; hardware flag set beats a software clear
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            timer_control_q <= `RESET_ZERO;
            ie_q <= `RESET_ZERO;
            ip_q <= `RESET_ZERO;
            extra_irq_control_q <= `RESET_ZERO;
        end else begin
            timer_control_q <= timer_control_d;
            extra_irq_control_q <= extra_irq_control_d;
            ie_q <= ie_d;
            ip_q <= ip_d;
        end
    end

    // power modes; a wake clears the mode bits so the core resumes
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            power_control_q <= `RESET_POWER_CONTROL;
            core_clk_en_o <= 1'b1;
            osc_run_o <= 1'b1;
        end else begin
            if (sfr_wr_i && sfr_addr_i == `ADDR_POWER_CONTROL) begin
                power_control_q <= sfr_wdata_i;
            end else if (power_control_q[`POWER_CONTROL_PDOWN_BIT]) begin
                if (pd_wake) begin
                    power_control_q[`POWER_CONTROL_PDOWN_BIT] <= 1'b0;
                end
            end else if (power_control_q[`POWER_CONTROL_IDLE_BIT] && (|act)) begin
                power_control_q[`POWER_CONTROL_IDLE_BIT] <= 1'b0;
            end
            // only the write strobe or a wake steers the clocks
            core_clk_en_o <= ~(power_control_q[`POWER_CONTROL_IDLE_BIT] |
                               power_control_q[`POWER_CONTROL_PDOWN_BIT]);
            osc_run_o <= ~power_control_q[`POWER_CONTROL_PDOWN_BIT];
        end
    end

    // in-service levels; reti closes the higher level first
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            in_hi_q <= 1'b0;
            in_lo_q <= 1'b0;
        end else begin
            if (svc) begin
                if (pri[sel_q]) begin
                    in_hi_q <= 1'b1;
                end else begin
                    in_lo_q <= 1'b1;
                end
            end else if (reti_i) begin
                if (in_hi_q) begin
                    in_hi_q <= 1'b0;
                end else begin
                    in_lo_q <= 1'b0;
                end
            end
        end
    end

    // request stage; the vector follows the winner every cycle until an ack
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sel_q <= `SRC_EXT0;
            irq_req_o <= 1'b0;
            irq_vector_o <= `RESET_ZERO;
        end else if (svc) begin
            irq_req_o <= 1'b0;
        end else begin
            irq_req_o <= want;
            sel_q <= win;
            irq_vector_o <= `VEC_BASE |
                ({5'h00, win} << `VEC_STEP_SHIFT);
        end
    end

    // unmapped addresses read as zero
    reg [7:0] rd_mux;
    always @* begin
        if (sfr_addr_i == `ADDR_EXTRA_CONTROL) begin
            rd_mux = extra_irq_control_q;
        end else if (sfr_addr_i == `ADDR_TIMER_CONTROL) begin
            rd_mux = timer_control_q;
        end else if (sfr_addr_i == `ADDR_INT_ENABLE) begin
            rd_mux = ie_q;
        end else if (sfr_addr_i == `ADDR_INT_PRIORITY) begin
            rd_mux = ip_q;
        end else if (sfr_addr_i == `ADDR_POWER_CONTROL) begin
            rd_mux = power_control_q;
        end else begin
            rd_mux = `RESET_ZERO;
        end
    end

    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sfr_rdata_o <= `RESET_ZERO;
        end else if (sfr_rd_i) begin
            sfr_rdata_o <= rd_mux;
        end
    end

endmodule // eight_source_irq_and_wakeup
`default_nettype wire

// ---- sim/irq_chk_asserts.sv ----
// assertion checker for the interrupt and wake-up block
`timescale 1ns/10ps
`default_nettype none
module irq_chk (
    input wire logic       clk_i,
    input wire logic       rst_i,
    input wire logic [7:0] sfr_addr_i,
    input wire logic [7:0] sfr_wdata_i,
    input wire logic       sfr_wr_i,
    input wire logic       sfr_rd_i,
    input wire logic       ext_request_zero_n_i,
    input wire logic       ext_request_one_n_i,
    input wire logic       irq_ack_i,
    input wire logic [7:0] sfr_rdata_o,
    input wire logic       irq_req_o,
    input wire logic [7:0] irq_vector_o,
    input wire logic       core_clk_en_o,
    input wire logic       osc_run_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire pw = sfr_wr_i && sfr_addr_i == 8'h87;
    wire hit = sfr_addr_i inside {8'h87, 8'h88, 8'ha8, 8'hb8, 8'hc0};
    a_unmapped_rd_zero: assert property (
        sfr_rd_i && !hit |=> sfr_rdata_o == 8'h00) else $error("bad read");
    a_rdata_stands: assert property (
        !$past(sfr_rd_i) |-> $stable(sfr_rdata_o)) else $error("rdata moved");
    a_vector_legal: assert property (
        irq_req_o |-> irq_vector_o[2:0] == 3'h3 && irq_vector_o[7:6] == 2'h0)
        else $error("bad vector");
    a_ack_no_same: assert property (
        irq_ack_i && irq_req_o |=> !irq_req_o
        || irq_vector_o != $past(irq_vector_o)) else $error("same level");
    a_idle_cause: assert property (
        $fell(core_clk_en_o) |-> $past(pw && sfr_wdata_i[1:0] != 2'h0, 2))
        else $error("core clock stop");
    a_pd_cause: assert property (
        $fell(osc_run_o) |-> $past(pw && sfr_wdata_i[1], 2))
        else $error("osc stop");
    a_pd_all_clk: assert property (
        !osc_run_o |-> !core_clk_en_o) else $error("core runs in pd");
    a_pd_wake_src: assert property (
        $rose(osc_run_o) |-> !$past(ext_request_zero_n_i)
        || !$past(ext_request_one_n_i) || !$past(ext_request_zero_n_i, 2)
        || !$past(ext_request_one_n_i, 2)) else $error("bad wake");
endmodule // irq_chk
bind eight_source_irq_and_wakeup irq_chk irq_chk_inst (.clk_i, .rst_i,
    .sfr_addr_i, .sfr_wdata_i, .sfr_wr_i, .sfr_rd_i, .ext_request_zero_n_i,
    .ext_request_one_n_i, .irq_ack_i, .sfr_rdata_o, .irq_req_o,
    .irq_vector_o, .core_clk_en_o, .osc_run_o);
`default_nettype wire

// ---- sim/irq_pin_model.sv ----
// active-low request pins of the external peripherals
`timescale 1ns/10ps
`default_nettype none
module irq_pin_model (
    input  wire logic       clk_i,
    input  wire logic [3:0] pull_low_i,
    output var  logic [3:0] pin_n_o
);
    // released pins rest high on their pull-ups
    initial pin_n_o = 4'hf;
    always @(posedge clk_i) pin_n_o <= ~pull_low_i;
endmodule // irq_pin_model
`default_nettype wire

// ---- sim/tb_top.sv ----
// testbench for the interrupt and wake-up block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic       clk_i, rst_i, wr, rd, bwr, bv, ack, reti;
    logic [7:0] addr, wd, ba;
    logic [3:0] req;
    logic [1:0] mode;
    wire  [3:0] pn;
    wire  [7:0] rdata, vec;
    wire        irq, cen, osc;
    int         errors, tests_run;
    eight_source_irq_and_wakeup eight_source_irq_and_wakeup_inst (
        .clk_i(clk_i), .rst_i(rst_i), .sfr_addr_i(addr), .sfr_wdata_i(wd),
        .sfr_wr_i(wr), .sfr_rd_i(rd), .bit_addr_i(ba), .bit_wr_i(bwr),
        .bit_val_i(bv), .ext_request_zero_n_i(pn[0]),
        .ext_request_one_n_i(pn[1]), .aux_port_pin_two_i(pn[3]),
        .aux_port_pin_three_i(pn[2]), .aux_pin_two_mode_i(2'h0),
        .aux_pin_three_mode_i(mode), .timer0_ovf_i(1'b0),
        .timer1_ovf_i(1'b0), .serial_irq_i(1'b0), .timer2_irq_i(1'b0),
        .irq_ack_i(ack), .reti_i(reti), .sfr_rdata_o(rdata),
        .irq_req_o(irq), .irq_vector_o(vec), .core_clk_en_o(cen),
        .osc_run_o(osc));
    irq_pin_model irq_pin_model_inst (.clk_i(clk_i), .pull_low_i(req),
        .pin_n_o(pn));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // driven inputs change one ns after the rising edge; the pin model's pn changes on the edge itself
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
        addr = a;
        wd = d;
        wr = 1'b1;
        cyc(1);
        wr = 1'b0;
        cyc(1);
    endtask
    task automatic sfr_read(input logic [7:0] a, input logic [7:0] e);
        addr = a;
        rd = 1'b1;
        cyc(1);
        rd = 1'b0;
        chk(rdata, e);
        cyc(1);
    endtask
    task automatic bit_write(input logic [7:0] a, input logic v);
        ba = a;
        bv = v;
        bwr = 1'b1;
        cyc(1);
        bwr = 1'b0;
        cyc(1);
    endtask
    task automatic strobe(input logic is_ack);
        ack = is_ack;
        reti = !is_ack;
        cyc(1);
        ack = 1'b0;
        reti = 1'b0;
        cyc(1);
    endtask
    task automatic print_verdict;
        if (errors == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    initial begin
        #100000;
        errors++;
        print_verdict();
    end
    initial begin
        {rst_i, wr, rd, bwr, bv, ack, reti} = 7'h40;
        {addr, wd, ba, req} = 28'h0;
        mode = 2'h0;
        cyc(4);
        rst_i = 1'b0;
        sfr_read(8'h87, 8'h30);
        foreach (wd[i]) if (i < 4) sfr_read(8'h88 + 8'h20 * i, 8'h00);
        sfr_read(8'h90, 8'h00);
        sfr_write(8'ha8, 8'h81);
        bit_write(8'hc2, 1'b1);
        bit_write(8'hc0, 1'b1);
        sfr_read(8'hc0, 8'h05);
        mode = 2'h1;
        req = 4'h4;
        cyc(3);
        req = 4'h0;
        cyc(3);
        mode = 2'h0;
        sfr_read(8'hc0, 8'h05);
        req = 4'h5;
        cyc(4);
        chk({7'h0, irq}, 8'h01);
        chk(vec, 8'h03);
        req = 4'h1;
        strobe(1'b1);
        cyc(1);
        chk({7'h0, irq}, 8'h00);
        bit_write(8'hc3, 1'b1);
        cyc(2);
        chk(vec, 8'h33);
        sfr_read(8'hc0, 8'h0f);
        strobe(1'b1);
        cyc(1);
        sfr_read(8'hc0, 8'h0d);
        req = 4'h0;
        strobe(1'b0);
        strobe(1'b0);
        bit_write(8'hc2, 1'b0);
        req = 4'h4;
        cyc(3);
        req = 4'h0;
        cyc(3);
        chk({7'h0, irq}, 8'h00);
        sfr_write(8'hc0, 8'h00);
        sfr_write(8'h87, 8'h01);
        cyc(1);
        chk({6'h0, osc, cen}, 8'h02);
        req = 4'h1;
        cyc(5);
        chk({7'h0, cen}, 8'h01);
        req = 4'h0;
        cyc(3);
        sfr_write(8'h87, 8'h02);
        cyc(1);
        chk({6'h0, osc, cen}, 8'h00);
        req = 4'h2;
        cyc(5);
        chk({7'h0, osc}, 8'h00);
        req = 4'h1;
        cyc(5);
        chk({7'h0, osc}, 8'h01);
        req = 4'h0;
        sfr_write(8'h87, 8'h01);
        cyc(2);
        rst_i = 1'b1;
        cyc(1);
        rst_i = 1'b0;
        chk({7'h0, cen}, 8'h01);
        sfr_read(8'ha8, 8'h00);
        print_verdict();
    end
endmodule // tb_top
`default_nettype wire
